// ---- design/servo_device.sv ----
/*
  Servo device end: focus search and close, track jump auto-sequence with
  crossing count and brake, carriage threshold drive, slicer threshold and
  spindle modes with frame-sync loss detection.
  Assumes ADC samples and the sync match strobe are on clk; comparator pins
  and the frame clock are asynchronous.
*/
`timescale 1ns/1ps
module servo_device
  import servo_pkg::*;
#(
  parameter int HOLD_CYCLES = BRAKE_HOLD_CYCLES,
  parameter int SWEEP_LIMIT = 100,
  parameter int CARR_GAIN = 4,
  parameter int CARR_THRESH = 1024,
  parameter int LP_SHIFT = 6,
  parameter int RUN_WINDOW = 4000,
  parameter int SLOW_RUN = 40,
  parameter int NOMINAL_RUN = 12
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to host
  servo_link_if.device link,
  // Sampled analog inputs
  input wire logic signed [7:0] focus_error,
  input wire logic signed [11:0] tracking_eq_out,
  input wire logic sync_match,
  // Asynchronous pins
  input wire logic track_zero_cross_signal,
  input wire logic mirror_detect,
  input wire logic rf_present_flag,
  input wire logic efm_bit,
  input wire logic frame_clock,
  // Drives
  output logic signed [7:0] focus_drive,
  output logic focus_loop_closed,
  output drive_dir_t track_drive,
  output logic track_loop_closed,
  output logic track_gain_boost,
  output logic signed [15:0] carriage_drive,
  output logic signed [7:0] spindle_drive,
  output logic leadin_servo_sel,
  output logic [7:0] slice_reference
);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------------
  logic [4:0] pin_meta, pin_sync;
  logic tec_prev, fck_prev, efm_prev;
  logic tec_rise, tec_edge, fck_rise;

  always_ff @(posedge clk)
  begin
    pin_meta <= {track_zero_cross_signal, mirror_detect, rf_present_flag, efm_bit, frame_clock};
    pin_sync <= pin_meta;
    tec_prev <= pin_sync[4];
    fck_prev <= pin_sync[0];
    efm_prev <= pin_sync[1];
  end

  assign tec_edge = pin_sync[4] ^ tec_prev;
  assign tec_rise = pin_sync[4] & ~tec_prev;
  assign fck_rise = pin_sync[0] & ~fck_prev;

  // ----------------------------------------------------------------------
  // Slicer threshold
  // ----------------------------------------------------------------------
  // Ones push the threshold up, zeros pull it down, so it settles where the
  // two are equally likely; saturating keeps a dead input from wrapping.
  always_ff @(posedge clk)
  begin
    if (rst)
      slice_reference <= SLICE_RESET;
    else if (pin_sync[1] && slice_reference != 8'hff)
      slice_reference <= slice_reference + 8'h1;
    else if (!pin_sync[1] && slice_reference != 8'h00)
      slice_reference <= slice_reference - 8'h1;
  end

  // ----------------------------------------------------------------------
  // Focus search and close
  // ----------------------------------------------------------------------
  logic sweep_up, fe_sign_prev, fe_cross;
  assign fe_cross = focus_error[7] ^ fe_sign_prev;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link.focus_search_status <= 1'b0;
      focus_loop_closed <= 1'b0;
      focus_drive <= 8'sh00;
      sweep_up <= 1'b1;
      fe_sign_prev <= 1'b0;
    end
    else
    begin
      fe_sign_prev <= focus_error[7];
      if (link.cmd_valid && link.cmd_op == CMD_FOCUS_SEARCH)
      begin
        link.focus_search_status <= 1'b1;
        focus_loop_closed <= 1'b0;
      end
      else if (link.focus_search_status)
      begin
        if (sweep_up && pin_sync[2] && fe_cross)
        begin
          link.focus_search_status <= 1'b0;
          focus_loop_closed <= 1'b1;
        end
        else if (sweep_up)
        begin
          focus_drive <= focus_drive + 8'sh01;
          sweep_up <= (focus_drive < 8'(SWEEP_LIMIT - 1));
        end
        else
        begin
          focus_drive <= focus_drive - 8'sh01;
          sweep_up <= (focus_drive <= 8'(1 - SWEEP_LIMIT));
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Track jump sequence and brake
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    T_OPEN = 3'b000,
    T_KICK = 3'b001,
    T_BRAKE = 3'b010,
    T_HOLD = 3'b011,
    T_PLAY = 3'b100
  } tstate_t;
  tstate_t tstate;
  logic [7:0] cross_cnt, target, brake_left;
  logic [31:0] hold_cnt;
  logic jump_rev, repeating, lens_outward;

  function automatic drive_dir_t dir_of(input logic rev);
    dir_of = rev ? DRV_REV : DRV_FWD;
  endfunction

  // Mirror level at a rising crossing tells which way the lens slips.
  always_ff @(posedge clk)
  begin
    if (rst)
      lens_outward <= 1'b0;
    else if (tec_rise)
      lens_outward <= pin_sync[3];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tstate <= T_OPEN;
      cross_cnt <= 8'h0;
      target <= 8'h0;
      brake_left <= 8'h0;
      hold_cnt <= 32'h0;
      jump_rev <= 1'b0;
      repeating <= 1'b0;
    end
    else
    begin
      if (link.cmd_valid && link.cmd_op == CMD_REPEAT_OFF)
        repeating <= 1'b0;
      if (link.cmd_valid && link.cmd_op == CMD_TRACK_OPEN)
        tstate <= T_OPEN;
      else if (link.cmd_valid && tstate != T_KICK && tstate != T_BRAKE
               && (link.cmd_op == CMD_JUMP || link.cmd_op == CMD_REPEAT_ON))
      begin
        tstate <= T_KICK;
        target <= link.cmd_target;
        jump_rev <= link.cmd_dir_rev;
        repeating <= (link.cmd_op == CMD_REPEAT_ON);
        cross_cnt <= 8'h0;
      end
      else
      begin
        unique case (tstate)
          T_OPEN, T_PLAY: ;
          T_KICK:
            if (cross_cnt == target)
            begin
              tstate <= T_BRAKE;
              // The compare cycle already drives the brake, so it counts as one
              brake_left <= (link.brake_width == 8'h0) ? 8'h0 : link.brake_width - 8'h1;
            end
            else if (tec_edge)
              cross_cnt <= cross_cnt + 8'h1;
          T_BRAKE:
            if (brake_left <= 8'h1)
            begin
              tstate <= T_HOLD;
              hold_cnt <= 32'h0;
            end
            else
              brake_left <= brake_left - 8'h1;
          T_HOLD:
            if (repeating && hold_cnt >= 32'(HOLD_CYCLES / REPEAT_SPEEDUP))
            begin
              tstate <= T_KICK;
              cross_cnt <= 8'h0;
            end
            else if (hold_cnt >= 32'(HOLD_CYCLES - 1))
              tstate <= T_PLAY;
            else
              hold_cnt <= hold_cnt + 32'h1;
          default: tstate <= T_OPEN;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      track_drive <= DRV_NONE;
    else if (tstate == T_KICK && cross_cnt != target)
      track_drive <= dir_of(jump_rev);
    else if (tstate == T_KICK || tstate == T_BRAKE)
      track_drive <= dir_of(!jump_rev);
    else if (tstate == T_HOLD)
      track_drive <= dir_of(!lens_outward);
    else
      track_drive <= DRV_NONE;
  end

  assign track_loop_closed = (tstate == T_HOLD) || (tstate == T_PLAY);
  assign track_gain_boost = (tstate == T_HOLD);
  assign link.jump_busy = (tstate == T_KICK) || (tstate == T_BRAKE) || repeating;

  // ----------------------------------------------------------------------
  // Carriage drive
  // ----------------------------------------------------------------------
  logic signed [19:0] carr_lp;
  logic signed [23:0] carr_scaled;
  assign carr_scaled = 24'(carr_lp >>> LP_SHIFT) * 24'(CARR_GAIN);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      carr_lp <= 20'sh0;
      carriage_drive <= 16'sh0;
    end
    else
    begin
      carr_lp <= carr_lp + 20'(tracking_eq_out) - 20'(carr_lp >>> LP_SHIFT);
      if (carr_scaled > 24'(CARR_THRESH) || carr_scaled < 24'(-CARR_THRESH))
        carriage_drive <= 16'(carr_scaled);
      else
        carriage_drive <= 16'sh0;
    end
  end

  // ----------------------------------------------------------------------
  // Run length and frame sync
  // ----------------------------------------------------------------------
  logic [7:0] run_len, run_max, run_est;
  logic [15:0] win_cnt;
  logic [3:0] frame_div;
  logic [3:0] miss_cnt;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run_len <= 8'h0;
      run_max <= 8'h0;
      run_est <= 8'h0;
      win_cnt <= 16'h0;
    end
    else
    begin
      run_len <= (pin_sync[1] != efm_prev) ? 8'h1 : run_len + {7'h0, run_len != 8'hff};
      if (win_cnt >= 16'(RUN_WINDOW - 1))
      begin
        win_cnt <= 16'h0;
        run_est <= run_max;
        run_max <= 8'h0;
      end
      else
      begin
        win_cnt <= win_cnt + 16'h1;
        if (run_len > run_max)
          run_max <= run_len;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      link.slowdown_flag <= 1'b0;
    else if (link.spindle_mode == SPIN_BRAKE && run_est > 8'(SLOW_RUN))
      link.slowdown_flag <= 1'b1;
    else if (link.spindle_mode != SPIN_BRAKE)
      link.slowdown_flag <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frame_div <= 4'h0;
      miss_cnt <= 4'h0;
    end
    else if (fck_rise)
    begin
      frame_div <= frame_div + 4'h1;
      if (frame_div == 4'(SYNC_SAMPLE_DIV - 1))
      begin
        if (sync_match)
          miss_cnt <= 4'h0;
        else if (miss_cnt != 4'(SYNC_LOSS_COUNT))
          miss_cnt <= miss_cnt + 4'h1;
      end
    end
  end

  assign link.sync_lost = (miss_cnt == 4'(SYNC_LOSS_COUNT));

  // ----------------------------------------------------------------------
  // Spindle drive
  // ----------------------------------------------------------------------
  // Focus search overrides the commanded mode so the disc keeps spinning up.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      spindle_drive <= SPIN_ZERO;
      leadin_servo_sel <= 1'b0;
    end
    else if (link.focus_search_status)
    begin
      spindle_drive <= SPIN_FULL_FWD;
      leadin_servo_sel <= 1'b0;
    end
    else
    begin
      leadin_servo_sel <= (link.spindle_mode == SPIN_APPLICABLE) && link.sync_lost;
      unique case (link.spindle_mode)
        SPIN_KICK: spindle_drive <= SPIN_FULL_FWD;
        SPIN_OFFSET_MODE: spindle_drive <= SPIN_OFFSET;
        SPIN_APPLICABLE: spindle_drive <= link.sync_lost ? SPIN_LEADIN : SPIN_NORMAL;
        SPIN_BRAKE: spindle_drive <= SPIN_FULL_REV;
        SPIN_STOP: spindle_drive <= SPIN_ZERO;
        SPIN_ROUGH: spindle_drive <= (run_est > 8'(NOMINAL_RUN)) ? SPIN_FULL_FWD
                                                                  : SPIN_FULL_REV;
        SPIN_HOLD: spindle_drive <= spindle_drive;
        default: spindle_drive <= SPIN_ZERO;
      endcase
    end
  end

endmodule

// ---- common/servo_pkg.sv ----
/*
  Shared constants and types for the optical disc servo sequencer: command
  codes, spindle modes, drive directions, timing figures and reset values.
  Assumes a single 40 MHz system clock shared by both ends.
*/
// How it works
// - Track zero crossings counted, lens direction sensed
// - Slice threshold steered toward equal ones/zeros
// - Focus search sweeps triangle, spindle forced kick
// - Focus closes: rising, RF present, error crosses
// - Focus search status falls when loop closes
// - Host watches filtered RF 10 ms after fall
// - Host starts protection if filtered RF low
// - Jumps auto-sequenced; sizes 1, 4, 100 tracks
// - Host loads half-count target and brake width
// - Crossing count hits target, brake pulse fires
// - Then close tracking, 50 ms brake, gain boost
// - Repeat mode chains single jumps ten times faster
// - Brake drives opposite to sensed lens direction
// - Carriage drive is low-passed tracking output, amplified
// - Carriage drive only above preset threshold
// - Seven spindle modes including kick and offset
// - Sync sampled every 16 frames; eight misses lose
// - Applicable servo: lead-in when lost, else normal
// - Brake mode flags slow-down on long run
// - Host drops brake on flag, else stop, eject
// - Stop mode drives spindle at zero volts
// - Rough servo drives high/low from run estimate
package servo_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int RF_WATCH_MS = 10;
  localparam int BRAKE_HOLD_MS = 50;
  localparam int RF_WATCH_CYCLES = CLK_HZ / 1000 * RF_WATCH_MS;
  localparam int BRAKE_HOLD_CYCLES = CLK_HZ / 1000 * BRAKE_HOLD_MS;
  localparam int REPEAT_SPEEDUP = 10;
  localparam int SYNC_SAMPLE_DIV = 16;
  localparam int SYNC_LOSS_COUNT = 8;

  // ----------------------------------------------------------------------
  // Jump sizes and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] JUMP_SMALL = 8'h01;
  localparam logic [7:0] JUMP_MID = 8'h04;
  localparam logic [7:0] JUMP_LARGE = 8'h64;
  localparam logic [7:0] SLICE_RESET = 8'h80;
  localparam logic signed [7:0] SPIN_FULL_FWD = 8'sh7f;
  localparam logic signed [7:0] SPIN_FULL_REV = -8'sh7f;
  localparam logic signed [7:0] SPIN_OFFSET = 8'sh20;
  localparam logic signed [7:0] SPIN_LEADIN = 8'sh40;
  localparam logic signed [7:0] SPIN_NORMAL = 8'sh10;
  localparam logic signed [7:0] SPIN_ZERO = 8'sh00;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_FOCUS_SEARCH = 3'h1,
    CMD_JUMP = 3'h2,
    CMD_REPEAT_ON = 3'h3,
    CMD_REPEAT_OFF = 3'h4,
    CMD_TRACK_OPEN = 3'h5
  } cmd_t;

  typedef enum logic [2:0] {
    SPIN_STOP = 3'h0,
    SPIN_KICK = 3'h1,
    SPIN_OFFSET_MODE = 3'h2,
    SPIN_APPLICABLE = 3'h3,
    SPIN_BRAKE = 3'h4,
    SPIN_ROUGH = 3'h5,
    SPIN_HOLD = 3'h6
  } spin_mode_t;

  typedef enum logic [1:0] {
    DRV_NONE = 2'h0,
    DRV_FWD = 2'h1,
    DRV_REV = 2'h2
  } drive_dir_t;

endpackage

// ---- common/servo_link_if.sv ----
/*
  Command link between the control processor end and the servo device end.
  Both ends run on the same clock; commands are one-cycle pulses.
*/
`timescale 1ns/1ps
interface servo_link_if;
  import servo_pkg::*;
  logic cmd_valid;
  cmd_t cmd_op;
  logic cmd_dir_rev;
  logic [7:0] cmd_target;
  logic [7:0] brake_width;
  spin_mode_t spindle_mode;
  logic focus_search_status;
  logic slowdown_flag;
  logic sync_lost;
  logic jump_busy;

  modport device (
    input cmd_valid, cmd_op, cmd_dir_rev, cmd_target, brake_width, spindle_mode,
    output focus_search_status, slowdown_flag, sync_lost, jump_busy
  );
  modport host (
    output cmd_valid, cmd_op, cmd_dir_rev, cmd_target, brake_width, spindle_mode,
    input focus_search_status, slowdown_flag, sync_lost, jump_busy
  );
endinterface

// ---- design/servo_host.sv ----
/*
  Control processor end: issues focus, jump and spindle commands, watches the
  filtered RF-present signal after focus closes, and runs spindle braking.
  Assumes the filtered RF-present pin is asynchronous.
*/
`timescale 1ns/1ps
module servo_host
  import servo_pkg::*;
#(
  parameter int WATCH_CYCLES = RF_WATCH_CYCLES,
  parameter int SLOW_TIMEOUT = 8000,
  parameter int STOP_HOLD = 8000,
  parameter logic [7:0] BRAKE_PULSE = 8'h10
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to device
  servo_link_if.host link,
  // User requests
  input wire logic start_focus,
  input wire logic jump_req,
  input wire logic [1:0] jump_size,
  input wire logic jump_rev,
  input wire logic repeat_on,
  input wire logic repeat_off,
  input wire logic stop_disc,
  input wire logic eject_after,
  input wire logic [2:0] play_mode,
  // Pins
  input wire logic filtered_rf_present,
  // Status
  output logic protect,
  output logic eject,
  output logic braking
);

  // ----------------------------------------------------------------------
  // Filtered RF watch
  // ----------------------------------------------------------------------
  logic rf_meta, rf_sync, fss_prev, watching;
  logic [31:0] watch_cnt;

  always_ff @(posedge clk)
  begin
    rf_meta <= filtered_rf_present;
    rf_sync <= rf_meta;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fss_prev <= 1'b0;
      watching <= 1'b0;
      watch_cnt <= 32'h0;
      protect <= 1'b0;
    end
    else
    begin
      fss_prev <= link.focus_search_status;
      protect <= 1'b0;
      if (fss_prev && !link.focus_search_status)
      begin
        watch_cnt <= 32'h1;
        watching <= 1'b0;
      end
      else if (watch_cnt != 32'h0)
      begin
        if (watch_cnt >= 32'(WATCH_CYCLES))
        begin
          watch_cnt <= 32'h0;
          watching <= 1'b1;
        end
        else
          watch_cnt <= watch_cnt + 32'h1;
      end
      else if (watching && !rf_sync)
      begin
        protect <= 1'b1;
        watching <= 1'b0;
      end
      if (link.focus_search_status)
        watching <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------------
  function automatic logic [7:0] half_target(input logic [1:0] sel);
    logic [7:0] n;
    n = (sel == 2'h0) ? JUMP_SMALL : (sel == 2'h1) ? JUMP_MID : JUMP_LARGE;
    half_target = (n + 8'h1) >> 1;
  endfunction

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link.cmd_valid <= 1'b0;
      link.cmd_op <= CMD_NOP;
      link.cmd_dir_rev <= 1'b0;
      link.cmd_target <= 8'h0;
      link.brake_width <= BRAKE_PULSE;
    end
    else
    begin
      link.cmd_valid <= start_focus | jump_req | repeat_on | repeat_off;
      link.brake_width <= BRAKE_PULSE;
      if (start_focus)
        link.cmd_op <= CMD_FOCUS_SEARCH;
      else if (jump_req)
      begin
        link.cmd_op <= CMD_JUMP;
        link.cmd_target <= half_target(jump_size);
        link.cmd_dir_rev <= jump_rev;
      end
      else if (repeat_on)
      begin
        link.cmd_op <= CMD_REPEAT_ON;
        link.cmd_target <= half_target(2'h0);
        link.cmd_dir_rev <= jump_rev;
      end
      else if (repeat_off)
        link.cmd_op <= CMD_REPEAT_OFF;
      else
        link.cmd_op <= CMD_NOP;
    end
  end

  // ----------------------------------------------------------------------
  // Spindle braking sequence
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    H_PLAY = 2'b00,
    H_BRAKE = 2'b01,
    H_STOP_HOLD = 2'b10,
    H_STOPPED = 2'b11
  } hstate_t;
  hstate_t hstate;
  logic [31:0] hcnt;
  logic eject_pending;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hstate <= H_STOPPED;
      hcnt <= 32'h0;
      eject <= 1'b0;
      eject_pending <= 1'b0;
    end
    else
    begin
      eject <= 1'b0;
      unique case (hstate)
        H_PLAY:
          if (stop_disc)
          begin
            hstate <= H_BRAKE;
            hcnt <= 32'h0;
            eject_pending <= eject_after;
          end
        H_BRAKE:
          if (link.slowdown_flag)
          begin
            hstate <= H_STOP_HOLD;
            hcnt <= 32'(STOP_HOLD);
          end
          else if (hcnt >= 32'(SLOW_TIMEOUT))
          begin
            hstate <= H_STOP_HOLD;
            hcnt <= 32'h0;
          end
          else
            hcnt <= hcnt + 32'h1;
        H_STOP_HOLD:
          if (hcnt >= 32'(STOP_HOLD))
          begin
            hstate <= H_STOPPED;
            eject <= eject_pending;
            eject_pending <= 1'b0;
          end
          else
            hcnt <= hcnt + 32'h1;
        H_STOPPED:
          if (start_focus)
            hstate <= H_PLAY;
      endcase
    end
  end

  assign braking = (hstate == H_BRAKE);

  always_comb
  begin
    unique case (hstate)
      H_PLAY: link.spindle_mode = spin_mode_t'(play_mode);
      H_BRAKE: link.spindle_mode = SPIN_BRAKE;
      H_STOP_HOLD: link.spindle_mode = SPIN_STOP;
      H_STOPPED: link.spindle_mode = SPIN_STOP;
    endcase
  end

endmodule

// ---- testbench/servo_link_properties.sv ----
/*
  Checker for the servo command link.
  Assumes one clock shared by both ends; sees only the link signals.
*/
`timescale 1ns/1ps
module servo_link_properties
  import servo_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link signals
  input wire logic cmd_valid,
  input wire cmd_t cmd_op,
  input wire logic [7:0] cmd_target,
  input wire spin_mode_t spindle_mode,
  input wire logic focus_search_status,
  input wire logic slowdown_flag,
  input wire logic jump_busy
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_PULSE:
    assert property (cmd_valid |=> !cmd_valid) else $error("strobe held");
  AST_IDLE_OP:
    assert property (!cmd_valid |-> cmd_op == CMD_NOP) else $error("stale op");
  AST_HALF_TARGET:
    assert property (cmd_valid && cmd_op == CMD_JUMP |-> cmd_target inside {8'h01, 8'h02, 8'h32})
    else $error("bad target");
  AST_SEARCH_START:
    assert property (cmd_valid && cmd_op == CMD_FOCUS_SEARCH |=> focus_search_status)
    else $error("no search");
  AST_SEARCH_CAUSE:
    assert property ($rose(focus_search_status) |-> $past(cmd_valid && cmd_op == CMD_FOCUS_SEARCH))
    else $error("search without command");
  AST_JUMP_BUSY:
    assert property (cmd_valid && cmd_op == CMD_JUMP && !jump_busy |=> jump_busy)
    else $error("jump not started");
  AST_FLAG_CLEAR:
    assert property (spindle_mode != SPIN_BRAKE |=> !slowdown_flag) else $error("flag outside brake");
  AST_BRAKE_DROP:
    assert property (slowdown_flag && spindle_mode == SPIN_BRAKE |-> ##[1:3] spindle_mode == SPIN_STOP)
    else $error("brake kept");
endmodule

// ---- testbench/optical_disc_servo_sequencer_tb.sv ----
/*
  Testbench joining host and device ends over the link.
  Assumes shortened hold, watch and timeout counts set below.
*/
`timescale 1ns/1ps
module optical_disc_servo_sequencer_tb;
  import servo_pkg::*;
  localparam int HOLD = 200;
  localparam int WATCH = 50;
  logic clk = 0, rst = 1;
  logic start_focus = 0, jump_req = 0, jump_rev = 0, repeat_on = 0, repeat_off = 0;
  logic stop_disc = 0, eject_after = 1, filtered_rf_present = 1, sync_match = 0;
  logic track_zero_cross_signal = 0, mirror_detect = 1, rf_present_flag = 0;
  logic efm_bit = 0, frame_clock = 0;
  logic [1:0] jump_size = 0;
  logic [2:0] play_mode = 3'h3;
  logic signed [7:0] focus_error = 0;
  logic signed [11:0] tracking_eq_out = 0;
  logic protect, eject, braking, focus_loop_closed, track_loop_closed;
  logic track_gain_boost, leadin_servo_sel;
  drive_dir_t track_drive;
  logic signed [15:0] carriage_drive;
  logic signed [7:0] spindle_drive, focus_drive;
  logic [7:0] slice_reference;
  logic [7:0] tgts [3] = '{8'h32, 8'h02, 8'h01};
  int n_mismatch = 0, n_checks = 0, i, j, k;
  int fmax = 0, fmin = 0;

  always #12.5 clk = ~clk;

  servo_link_if link();
  servo_host #(.WATCH_CYCLES(WATCH), .SLOW_TIMEOUT(100), .STOP_HOLD(100)) servo_host_inst (
    .clk, .rst, .link, .start_focus, .jump_req, .jump_size, .jump_rev, .repeat_on,
    .repeat_off, .stop_disc, .eject_after, .play_mode, .filtered_rf_present,
    .protect, .eject, .braking);
  servo_device #(.HOLD_CYCLES(HOLD), .RUN_WINDOW(64)) servo_device_inst (
    .clk, .rst, .link, .focus_error, .tracking_eq_out, .sync_match,
    .track_zero_cross_signal, .mirror_detect, .rf_present_flag, .efm_bit, .frame_clock,
    .focus_drive, .focus_loop_closed, .track_drive, .track_loop_closed,
    .track_gain_boost, .carriage_drive, .spindle_drive, .leadin_servo_sel,
    .slice_reference);
  servo_link_properties chk_inst (
    .clk, .rst, .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op),
    .cmd_target(link.cmd_target), .spindle_mode(link.spindle_mode),
    .focus_search_status(link.focus_search_status),
    .slowdown_flag(link.slowdown_flag), .jump_busy(link.jump_busy));

  // ----
  // Helpers
  // ----
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t wait ran out", $time);
      close_out();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Error sign flips every cycle so a crossing is always at hand
  task automatic search(input int n);
    for (i = 0; i < n && link.focus_search_status; i++)
    begin
      focus_error = i[0] ? 8'sd20 : -8'sd20;
      cyc(1);
      if (focus_drive > fmax) fmax = focus_drive;
      if (focus_drive < fmin) fmin = focus_drive;
    end
  endtask

  task automatic frames(input int n);
    repeat (n)
    begin
      frame_clock = 1;
      cyc(2);
      frame_clock = 0;
      cyc(2);
    end
  endtask

  task automatic run_jump(input int tgt, input int hold);
    for (i = 0; i < 20 && track_drive !== DRV_FWD; i++) cyc(1);
    tmo(i, 20);
    repeat (tgt)
    begin
      track_zero_cross_signal = !track_zero_cross_signal;
      cyc(2);
    end
    for (i = 0; i < 20 && track_drive !== DRV_REV; i++) cyc(1);
    tmo(i, 20);
    for (k = 0; k < 300 && track_drive === DRV_REV; k++) cyc(1);
    chk(k == 16 && track_loop_closed === 1'b1 && track_drive === DRV_FWD, "brake");
    for (k = 0; k < 300 && track_gain_boost === 1'b1; k++) cyc(1);
    // The first hold cycle overlaps the last cycle of brake drive
    chk(k + 1 == hold, "hold length");
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    cyc(12);
    // Looked at inside reset: the slicer moves on the first free edge
    chk(slice_reference === SLICE_RESET && spindle_drive === SPIN_ZERO, "reset");
    rst = 0;
    cyc(1);
    start_focus = 1;
    cyc(1);
    start_focus = 0;
    cyc(3);
    chk(link.focus_search_status === 1'b1 && spindle_drive === SPIN_FULL_FWD, "kick");
    search(600);
    chk(link.focus_search_status === 1'b1, "closed without rf");
    chk(fmax == 100 && fmin == -100, "sweep");
    rf_present_flag = 1;
    search(2000);
    tmo(i, 2000);
    chk(focus_loop_closed === 1'b1, "focus closed");
    filtered_rf_present = 0;
    for (i = 0; i < 200 && protect !== 1'b1; i++) cyc(1);
    tmo(i, 200);
    chk(i >= WATCH && i < WATCH + 8, "watch delay");
    filtered_rf_present = 1;
    for (j = 0; j < 3; j++)
    begin
      jump_size = 2'(2 - j);
      jump_req = 1;
      cyc(1);
      jump_req = 0;
      for (i = 0; i < 10 && link.cmd_valid !== 1'b1; i++) cyc(1);
      tmo(i, 10);
      chk(link.cmd_target === tgts[j], "jump target");
      run_jump(tgts[j], HOLD);
    end
    repeat_on = 1;
    cyc(1);
    repeat_on = 0;
    run_jump(1, HOLD / 10 + 1);
    repeat_off = 1;
    cyc(1);
    repeat_off = 0;
    track_zero_cross_signal = !track_zero_cross_signal;
    for (i = 0; i < 400 && link.jump_busy === 1'b1; i++) cyc(1);
    tmo(i, 400);
    tracking_eq_out = 12'sd100;
    frames(144);
    chk(link.sync_lost === 1'b1 && leadin_servo_sel === 1'b1, "sync lost");
    chk(carriage_drive === 16'sd0 && slice_reference === 8'h00, "below threshold");
    tracking_eq_out = 12'sd1000;
    sync_match = 1;
    frames(16);
    sync_match = 0;
    chk(link.sync_lost === 1'b0 && spindle_drive === SPIN_NORMAL, "sync back");
    frames(112);
    chk(link.sync_lost === 1'b0, "seven misses");
    frames(16);
    chk(link.sync_lost === 1'b1, "eight misses");
    cyc(700);
    chk(carriage_drive === 16'sd4000, "carriage drive");
    play_mode = 3'h2;
    cyc(2);
    chk(spindle_drive === SPIN_OFFSET, "offset");
    play_mode = 3'h5;
    cyc(2);
    chk(spindle_drive === SPIN_FULL_FWD, "rough");
    efm_bit = 1;
    stop_disc = 1;
    cyc(1);
    stop_disc = 0;
    chk(link.spindle_mode === SPIN_BRAKE && braking === 1'b1, "brake mode");
    // Idle data left long runs behind, so the slow-down flag sets at once
    for (i = 0; i < 400 && eject !== 1'b1; i++) cyc(1);
    tmo(i, 400);
    chk(i < 8, "flag ends brake");
    chk(link.spindle_mode === SPIN_STOP && spindle_drive === SPIN_ZERO, "stop");
    cyc(260);
    chk(slice_reference === 8'hff, "slice high");
    close_out();
  end
endmodule
